// ---- design/tcxu_pkg.sv ----
// Constants for the translation and cache-check fault capture unit.
// Assumes a 64-bit core with 32-bit register bus words and one clock.
package tcxu_pkg;
	// Vector offsets
	localparam logic [11:0] VEC_REFILL32  = 12'h000;
	localparam logic [11:0] VEC_REFILL64  = 12'h080;
	localparam logic [11:0] VEC_CACHE     = 12'h100;
	localparam logic [11:0] VEC_COMMON    = 12'h180;
	// Exception code field encodings
	localparam logic [4:0]  CODE_NONE     = 5'h00;
	localparam logic [4:0]  CODE_WPROT    = 5'h01;
	localparam logic [4:0]  CODE_LOADXL   = 5'h02;
	localparam logic [4:0]  CODE_STOREXL  = 5'h03;
	localparam logic [4:0]  CODE_CACHE    = 5'h1e;
	// Register word indices (byte address = 4 * index)
	localparam logic [5:0]  IDX_STATUS    = 6'h00;
	localparam logic [5:0]  IDX_CAUSE     = 6'h01;
	localparam logic [5:0]  IDX_RETPC_LO  = 6'h02;
	localparam logic [5:0]  IDX_RETPC_HI  = 6'h03;
	localparam logic [5:0]  IDX_BADVA_LO  = 6'h04;
	localparam logic [5:0]  IDX_BADVA_HI  = 6'h05;
	localparam logic [5:0]  IDX_PTE_LO    = 6'h06;
	localparam logic [5:0]  IDX_PTE_HI    = 6'h07;
	localparam logic [5:0]  IDX_WPTE_LO   = 6'h08;
	localparam logic [5:0]  IDX_WPTE_HI   = 6'h09;
	localparam logic [5:0]  IDX_TAG_LO    = 6'h0a;
	localparam logic [5:0]  IDX_TAG_HI    = 6'h0b;
	localparam logic [5:0]  IDX_DATA      = 6'h0c;
	localparam logic [5:0]  IDX_SLOT      = 6'h0d;
	localparam logic [5:0]  IDX_INDEX     = 6'h0e;
	localparam logic [5:0]  IDX_CFLOG     = 6'h0f;
	localparam logic [5:0]  IDX_CFADR_LO  = 6'h10;
	localparam logic [5:0]  IDX_CFADR_HI  = 6'h11;
	localparam logic [5:0]  IDX_BASE      = 6'h12;
	// Field positions
	localparam int STATUS_EXL     = 0;
	localparam int CAUSE_CODE_LSB = 2;
	localparam int CAUSE_BD       = 31;
	localparam int CFLOG_WAY_LSB  = 0;
	localparam int CFLOG_TYPE_LSB = 8;
	localparam int CFLOG_ITYPE    = 12;
	localparam int PTE_VPN_LSB    = 13;
	localparam int ADDRESS_SPACE_TAG_W         = 8;
	localparam int SLOT_W         = 6;
	localparam int WAY_W          = 2;
	localparam int LINE_W         = 7;
	// Reset values
	localparam logic [SLOT_W-1:0] SLOT_MAX   = 6'h3f;
	localparam logic [31:0]       BASE_RESET = 32'hbfc0_0000;
	// Uncached segment lies at 0xa0000000..0xbfffffff
	localparam logic [2:0]        UNCACHED_SEG = 3'h5;
	// Cache error kinds logged in the fault register
	localparam logic [1:0] CERR_IPARITY = 2'h1;
	localparam logic [1:0] CERR_DSINGLE = 2'h2;
	localparam logic [1:0] CERR_DDOUBLE = 2'h3;
endpackage : tcxu_pkg

// ---- design/tcxu_exception_unit.sv ----
// Fault detection and state capture for translation and cache-check faults.
// Assumes pipeline inputs synchronous to clk_sys and one fault per cycle
// presented at the instruction boundary; registers on a plain strobe port.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tcxu_exception_unit (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Translation lookup result for the current access
	input  wire logic        accValid,
	input  wire logic        accFetch,
	input  wire logic        accStore,
	input  wire logic        accMapped,
	input  wire logic        accWide,
	input  wire logic [63:0] accVaddr,
	input  wire logic [63:0] accPc,
	input  wire logic [63:0] accBranchPc,
	input  wire logic        accInDelaySlot,
	input  wire logic [7:0]  curAsid,
	input  wire logic        tlbHit,
	input  wire logic        tlbEntryValid,
	input  wire logic        tlbEntryDirty,
	input  wire logic        higherFault,
	// Probe operation
	input  wire logic        probeReq,
	input  wire logic        probeHit,
	input  wire logic [5:0]  probeIndex,
	// Cache checks
	input  wire logic        icCheckErr,
	input  wire logic [1:0]  icWay,
	input  wire logic [6:0]  icLine,
	input  wire logic        dcCheckErr,
	input  wire logic        dcDoubleErr,
	input  wire logic [1:0]  dcWay,
	input  wire logic [6:0]  dcLine,
	input  wire logic [39:0] dcPaddr,
	// Register port
	input  wire logic [5:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	// Dispatch and cache repair
	output logic             excTake,
	output logic      [63:0] excVector,
	output logic             icInvalidate,
	output logic      [1:0]  icInvWay,
	output logic      [6:0]  icInvLine,
	output logic             dcCorrect,
	output logic      [1:0]  dcFixWay,
	output logic      [6:0]  dcFixLine
);
	typedef enum logic [2:0] {
		FK_NONE, FK_REFILL, FK_INVALID, FK_MODIFY, FK_CACHE_I, FK_CACHE_D
	} tcxu_fault_e;

	tcxu_fault_e faultKind;
	logic        exlReg;
	logic [4:0]  codeReg;
	logic        bdReg;
	logic [63:0] retPcReg;
	logic [63:0] badVaReg;
	logic [63:0] ptePtrReg;
	logic [63:0] widePtePtrReg;
	logic [63:0] tagReg;
	logic [31:0] dataStageReg;
	logic [5:0]  slotReg;
	logic [5:0]  indexReg;
	logic [31:0] cfLogReg;
	logic [63:0] cfAddrReg;
	logic [31:0] baseReg;
	logic [31:0] ptePtrBaseReg;
	logic        takeNow;
	logic [11:0] vecOffset;
	logic [4:0]  codeNext;
	logic [31:0] rdataNext;

	// Fault detection in priority order; fetch-side cache faults rank above
	// data-side, and any earlier-stage fault suppresses this unit
	always_comb begin
		faultKind = FK_NONE;
		if (higherFault) begin
			faultKind = FK_NONE;
		end else if (accValid && accMapped && !tlbHit) begin
			faultKind = FK_REFILL;
		end else if (accValid && accMapped && !tlbEntryValid) begin
			faultKind = FK_INVALID;
		end else if (icCheckErr) begin
			faultKind = FK_CACHE_I;
		end else if (accValid && accMapped && accStore && !tlbEntryDirty) begin
			faultKind = FK_MODIFY;
		end else if (dcCheckErr) begin
			faultKind = FK_CACHE_D;
		end
	end

	assign takeNow = clkEn && (faultKind != FK_NONE);

	always_comb begin
		vecOffset = tcxu_pkg::VEC_COMMON;
		codeNext  = tcxu_pkg::CODE_NONE;
		unique case (faultKind)
			FK_NONE: begin
				vecOffset = tcxu_pkg::VEC_COMMON;
			end
			FK_REFILL: begin
				if (exlReg) begin
					vecOffset = tcxu_pkg::VEC_COMMON;
				end else if (accWide) begin
					vecOffset = tcxu_pkg::VEC_REFILL64;
				end else begin
					vecOffset = tcxu_pkg::VEC_REFILL32;
				end
				codeNext = (accStore && !accFetch) ? tcxu_pkg::CODE_STOREXL
					: tcxu_pkg::CODE_LOADXL;
			end
			FK_INVALID: begin
				vecOffset = tcxu_pkg::VEC_COMMON;
				codeNext  = (accStore && !accFetch) ? tcxu_pkg::CODE_STOREXL
					: tcxu_pkg::CODE_LOADXL;
			end
			FK_MODIFY: begin
				vecOffset = tcxu_pkg::VEC_COMMON;
				codeNext  = tcxu_pkg::CODE_WPROT;
			end
			FK_CACHE_I, FK_CACHE_D: begin
				vecOffset = tcxu_pkg::VEC_CACHE;
				codeNext  = tcxu_pkg::CODE_CACHE;
			end
		endcase
	end

	// Dispatch; cache error base is forced into the uncached segment so the
	// handler runs even while the caches are suspect
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			excTake   <= 1'b0;
			excVector <= 64'h0;
		end else if (clkEn) begin
			excTake <= takeNow;
			if (takeNow) begin
				if (faultKind == FK_CACHE_I || faultKind == FK_CACHE_D) begin
					excVector <= {32'hffff_ffff, tcxu_pkg::UNCACHED_SEG,
						baseReg[28:12], vecOffset};
				end else begin
					excVector <= {32'hffff_ffff, baseReg[31:12], vecOffset};
				end
			end
		end
	end

	// Exception level: set on every fault, software clears it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			exlReg <= 1'b0;
		end else if (clkEn) begin
			if (takeNow) begin
				exlReg <= 1'b1;
			end else if (regWr && regAddr == tcxu_pkg::IDX_STATUS) begin
				exlReg <= regWdata[tcxu_pkg::STATUS_EXL];
			end
		end
	end

	// Cause code, delay-slot flag and return PC
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			codeReg  <= tcxu_pkg::CODE_NONE;
			bdReg    <= 1'b0;
			retPcReg <= 64'h0;
		end else if (clkEn) begin
			if (takeNow) begin
				codeReg  <= codeNext;
				bdReg    <= accInDelaySlot;
				retPcReg <= accInDelaySlot ? accBranchPc : accPc;
			end else if (regWr && regAddr == tcxu_pkg::IDX_RETPC_LO) begin
				retPcReg[31:0] <= regWdata;
			end else if (regWr && regAddr == tcxu_pkg::IDX_RETPC_HI) begin
				retPcReg[63:32] <= regWdata;
			end
		end
	end

	// Translation fault capture; data staging is software-owned only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			badVaReg      <= 64'h0;
			ptePtrReg     <= 64'h0;
			widePtePtrReg <= 64'h0;
			tagReg        <= 64'h0;
			dataStageReg  <= 32'h0;
			ptePtrBaseReg <= 32'h0;
		end else if (clkEn) begin
			if (takeNow && (faultKind == FK_REFILL || faultKind == FK_INVALID
					|| faultKind == FK_MODIFY)) begin
				badVaReg      <= accVaddr;
				ptePtrReg     <= {ptePtrBaseReg, 9'h0,
					accVaddr[31:tcxu_pkg::PTE_VPN_LSB], 4'h0};
				widePtePtrReg <= {ptePtrBaseReg[31:0],
					accVaddr[40:tcxu_pkg::PTE_VPN_LSB], 4'h0};
				tagReg <= {accVaddr[63:tcxu_pkg::PTE_VPN_LSB], 5'h0,
					curAsid};
			end else if (regWr) begin
				unique case (regAddr)
					tcxu_pkg::IDX_TAG_LO: tagReg[31:0]  <= regWdata;
					tcxu_pkg::IDX_TAG_HI: tagReg[63:32] <= regWdata;
					tcxu_pkg::IDX_DATA:   dataStageReg  <= regWdata;
					tcxu_pkg::IDX_PTE_HI: ptePtrBaseReg <= regWdata;
					default: begin
					end
				endcase
			end
		end
	end

	// Replacement slot counts down every cycle with clkEn high and is always in range
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slotReg <= tcxu_pkg::SLOT_MAX;
		end else if (clkEn) begin
			slotReg <= slotReg - 6'h01;
		end
	end

	// Probe result; six bits leave no room for a no-match marker, so a miss
	// leaves the index as it was and software must test the hit itself
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			indexReg <= 6'h0;
		end else if (clkEn) begin
			if (probeReq && probeHit) begin
				indexReg <= probeIndex;
			end else if (regWr && regAddr == tcxu_pkg::IDX_INDEX) begin
				indexReg <= regWdata[5:0];
			end
		end
	end

	// Cache fault log and hardware repair actions
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfLogReg     <= 32'h0;
			cfAddrReg    <= 64'h0;
			icInvalidate <= 1'b0;
			icInvWay     <= 2'h0;
			icInvLine    <= 7'h0;
			dcCorrect    <= 1'b0;
			dcFixWay     <= 2'h0;
			dcFixLine    <= 7'h0;
		end else if (clkEn) begin
			icInvalidate <= takeNow && faultKind == FK_CACHE_I;
			dcCorrect    <= takeNow && faultKind == FK_CACHE_D
				&& !dcDoubleErr;
			if (takeNow && faultKind == FK_CACHE_I) begin
				cfLogReg  <= {19'h0, 1'b1, 2'h0, tcxu_pkg::CERR_IPARITY,
					6'h0, icWay};
				cfAddrReg <= accPc;
				icInvWay  <= icWay;
				icInvLine <= icLine;
			end else if (takeNow && faultKind == FK_CACHE_D) begin
				cfLogReg  <= {19'h0, 1'b0, 2'h0, dcDoubleErr
					? tcxu_pkg::CERR_DDOUBLE : tcxu_pkg::CERR_DSINGLE,
					6'h0, dcWay};
				cfAddrReg <= {24'h0, dcPaddr};
				dcFixWay  <= dcWay;
				dcFixLine <= dcLine;
			end
		end
	end

	// Exception base, written by software
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baseReg <= tcxu_pkg::BASE_RESET;
		end else if (clkEn && regWr && regAddr == tcxu_pkg::IDX_BASE) begin
			baseReg <= {regWdata[31:12], 12'h000};
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		rdataNext = 32'h0;
		unique case (regAddr)
			tcxu_pkg::IDX_STATUS:   rdataNext = {31'h0, exlReg};
			tcxu_pkg::IDX_CAUSE:    rdataNext = {bdReg, 24'h0, codeReg, 2'h0};
			tcxu_pkg::IDX_RETPC_LO: rdataNext = retPcReg[31:0];
			tcxu_pkg::IDX_RETPC_HI: rdataNext = retPcReg[63:32];
			tcxu_pkg::IDX_BADVA_LO: rdataNext = badVaReg[31:0];
			tcxu_pkg::IDX_BADVA_HI: rdataNext = badVaReg[63:32];
			tcxu_pkg::IDX_PTE_LO:   rdataNext = ptePtrReg[31:0];
			tcxu_pkg::IDX_PTE_HI:   rdataNext = ptePtrReg[63:32];
			tcxu_pkg::IDX_WPTE_LO:  rdataNext = widePtePtrReg[31:0];
			tcxu_pkg::IDX_WPTE_HI:  rdataNext = widePtePtrReg[63:32];
			tcxu_pkg::IDX_TAG_LO:   rdataNext = tagReg[31:0];
			tcxu_pkg::IDX_TAG_HI:   rdataNext = tagReg[63:32];
			tcxu_pkg::IDX_DATA:     rdataNext = dataStageReg;
			tcxu_pkg::IDX_SLOT:     rdataNext = {26'h0, slotReg};
			tcxu_pkg::IDX_INDEX:    rdataNext = {26'h0, indexReg};
			tcxu_pkg::IDX_CFLOG:    rdataNext = cfLogReg;
			tcxu_pkg::IDX_CFADR_LO: rdataNext = cfAddrReg[31:0];
			tcxu_pkg::IDX_CFADR_HI: rdataNext = cfAddrReg[63:32];
			tcxu_pkg::IDX_BASE:     rdataNext = baseReg;
			default:                rdataNext = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 32'h0;
		end else if (clkEn) begin
			regRdata <= regRd ? rdataNext : 32'h0;
		end
	end
endmodule : tcxu_exception_unit

// ---- test/tcxu_exception_unit_sva.sv ----
// Checker for the fault unit: dispatch, vectors and cache repair pulses.
// Sees only top-level ports; bound to every unit instance below.
`timescale 1ns/1ps
module tcxu_exception_unit_chk (
	// Clock and reset
	input wire logic		clk_sys,
	input wire logic		rst_n,
	input wire logic		clkEn,
	// Lookup and cache checks
	input wire logic		accValid,
	input wire logic		accStore,
	input wire logic		accMapped,
	input wire logic		accWide,
	input wire logic		tlbHit,
	input wire logic		tlbEntryValid,
	input wire logic		tlbEntryDirty,
	input wire logic		higherFault,
	input wire logic		icCheckErr,
	input wire logic		dcCheckErr,
	input wire logic		dcDoubleErr,
	// Register port
	input wire logic [5:0]	regAddr,
	input wire logic [31:0]	regWdata,
	input wire logic		regWr,
	// Dispatch and repair
	input wire logic		excTake,
	input wire logic [63:0]	excVector,
	input wire logic		icInvalidate,
	input wire logic		dcCorrect
);
	logic	miss, inval, modf, icf, dcf, go;
	logic	exl_reg;
	assign miss = accValid && accMapped && !tlbHit;
	assign inval = accValid && accMapped && tlbHit && !tlbEntryValid;
	assign modf = accValid && accMapped && tlbHit && tlbEntryValid
		&& accStore && !tlbEntryDirty;
	assign icf = icCheckErr && !miss && !inval;
	assign dcf = dcCheckErr && !miss && !inval && !icf && !modf;
	assign go = clkEn && !higherFault;
	// Shadow of the level bit: a taken fault beats a same-cycle write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			exl_reg <= 1'h0;
		else if (go && (miss || inval || modf || icf || dcf))
			exl_reg <= 1'h1;
		else if (clkEn && regWr && regAddr == tcxu_pkg::IDX_STATUS)
			exl_reg <= regWdata[tcxu_pkg::STATUS_EXL];
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence sTake(logic [11:0] off);
		excTake && excVector[11:0] == off;
	endsequence
	narrow_refill_a :
		assert property (go && miss && !exl_reg && !accWide |=> sTake(12'h000))
		else $error("narrow refill vector wrong");
	wide_refill_a :
		assert property (go && miss && !exl_reg && accWide |=> sTake(12'h080))
		else $error("wide refill vector wrong");
	nested_refill_a :
		assert property (go && miss && exl_reg |=> sTake(12'h180))
		else $error("nested refill not on common vector");
	invalid_common_a :
		assert property (go && inval |=> sTake(12'h180))
		else $error("invalid entry fault vector wrong");
	modify_common_a :
		assert property (go && modf |=> sTake(12'h180))
		else $error("modification fault vector wrong");
	cache_vector_a :
		assert property (go && icf |=> sTake(12'h100)
			##0 excVector[31:29] == tcxu_pkg::UNCACHED_SEG)
		else $error("cache fault vector wrong");
	ic_invalidate_a :
		assert property (go && icf |=> icInvalidate && !dcCorrect)
		else $error("instruction line not invalidated");
	dc_single_a :
		assert property (go && dcf && !dcDoubleErr |=> dcCorrect ##0 sTake(12'h100))
		else $error("single data error not corrected");
	dc_double_a :
		assert property (clkEn && dcCheckErr && dcDoubleErr |=> !dcCorrect)
		else $error("double data error corrected");
	higher_mask_a :
		assert property (clkEn && higherFault |=> !excTake)
		else $error("fault taken under higher priority");
endmodule : tcxu_exception_unit_chk

bind tcxu_exception_unit tcxu_exception_unit_chk u_chk (.*);

// ---- test/tcxu_pipe_model.sv ----
// Pipeline and lookup model: presents one access per call, then idles.
// Callers step on clk_sys; released data lines show inverted values.
`timescale 1ns/1ps
module tcxu_pipe_model (
	// Clock
	input wire logic		clk_sys,
	// Access and lookup result
	output logic			accValid,
	output logic			accFetch,
	output logic			accStore,
	output logic			accMapped,
	output logic			accWide,
	output logic [63:0]		accVaddr,
	output logic [63:0]		accPc,
	output logic [63:0]		accBranchPc,
	output logic			accInDelaySlot,
	output logic [7:0]		curAsid,
	output logic			tlbHit,
	output logic			tlbEntryValid,
	output logic			tlbEntryDirty,
	output logic			higherFault,
	// Probe
	output logic			probeReq,
	output logic			probeHit,
	output logic [5:0]		probeIndex,
	// Cache checks
	output logic			icCheckErr,
	output logic [1:0]		icWay,
	output logic [6:0]		icLine,
	output logic			dcCheckErr,
	output logic			dcDoubleErr,
	output logic [1:0]		dcWay,
	output logic [6:0]		dcLine,
	output logic [39:0]		dcPaddr
);
	initial begin
		{accValid, accFetch, accStore, accMapped, accWide, accVaddr, accPc,
			accBranchPc, accInDelaySlot, curAsid, tlbHit, tlbEntryValid,
			tlbEntryDirty, higherFault, probeReq, probeHit, probeIndex,
			icCheckErr, icWay, icLine, dcCheckErr, dcDoubleErr, dcWay,
			dcLine, dcPaddr} = '0;
	end
	// Kind: 0 miss, 1 invalid, 2 not writable, 3 icache, 4/5 dcache 1/2 bit
	task automatic issue(input logic [2:0] kind, input logic st, wd, bd, hf,
		input logic [63:0] va, pc);
		@(posedge clk_sys);
		accValid <= 1'h1;
		accFetch <= kind == 3'h3;
		accStore <= st;
		accMapped <= kind < 3'h3;
		accWide <= wd;
		accVaddr <= va;
		accPc <= pc;
		accBranchPc <= pc - 64'h4;
		accInDelaySlot <= bd;
		curAsid <= va[7:0] ^ 8'h3c;
		higherFault <= hf;
		tlbHit <= kind != 3'h0;
		tlbEntryValid <= kind != 3'h1;
		tlbEntryDirty <= kind != 3'h2;
		icCheckErr <= kind == 3'h3;
		dcCheckErr <= kind > 3'h3;
		dcDoubleErr <= kind == 3'h5;
		{icLine, icWay} <= va[8:0];
		{dcLine, dcWay} <= va[8:0];
		dcPaddr <= va[39:0];
		@(posedge clk_sys);
		{accValid, icCheckErr, dcCheckErr, higherFault} <= 4'h0;
		accVaddr <= ~va;
		dcPaddr <= ~va[39:0];
	endtask : issue
	task automatic probe(input logic hit, input logic [5:0] idx);
		@(posedge clk_sys);
		probeReq <= 1'h1;
		probeHit <= hit;
		probeIndex <= idx;
		@(posedge clk_sys);
		probeReq <= 1'h0;
		probeIndex <= ~idx;
	endtask : probe
endmodule : tcxu_pipe_model

// ---- test/tcxu_tb.sv ----
// Self-checking bench: a table of faults, register port checks and probe.
// The pipeline model drives lookups; the bench drives the register port.
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [2:0]		kind;
		logic			st, wd, bd, exception_level_bit;
		logic [11:0]	off;
		logic [4:0]		code;
	} tcxu_case_s;
	localparam tcxu_case_s CASES [9] = '{
		'{3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 12'h000, 5'h02},
		'{3'h0, 1'h1, 1'h1, 1'h0, 1'h1, 12'h180, 5'h03},
		'{3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 12'h080, 5'h03},
		'{3'h1, 1'h1, 1'h0, 1'h1, 1'h0, 12'h180, 5'h03},
		'{3'h1, 1'h0, 1'h0, 1'h0, 1'h0, 12'h180, 5'h02},
		'{3'h2, 1'h1, 1'h0, 1'h0, 1'h1, 12'h180, 5'h01},
		'{3'h3, 1'h0, 1'h0, 1'h1, 1'h0, 12'h100, 5'h1e},
		'{3'h4, 1'h0, 1'h0, 1'h0, 1'h0, 12'h100, 5'h1e},
		'{3'h5, 1'h1, 1'h0, 1'h0, 1'h0, 12'h100, 5'h1e}};
	logic			clk_sys, rst_n, clkEn, regWr, regRd, excTake;
	logic			accValid, accFetch, accStore, accMapped, accWide;
	logic			accInDelaySlot, tlbHit, tlbEntryValid, tlbEntryDirty;
	logic			higherFault, probeReq, probeHit, icInvalidate, dcCorrect;
	logic			icCheckErr, dcCheckErr, dcDoubleErr;
	logic [63:0]	accVaddr, accPc, accBranchPc, excVector;
	logic [39:0]	dcPaddr;
	logic [31:0]	regWdata, regRdata, slotSeen;
	logic [7:0]		curAsid;
	logic [6:0]		icLine, dcLine, icInvLine, dcFixLine;
	logic [5:0]		regAddr, probeIndex;
	logic [1:0]		icWay, dcWay, icInvWay, dcFixWay;
	int				err_count = 0;
	int				compares = 0;
	tcxu_exception_unit DUT (.*);
	tcxu_pipe_model pipe (.*);
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [63:0] got, exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'h0;
		regWdata <= ~d;
	endtask : wr
	task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'h0;
		#1 chk({32'h0, regRdata}, {32'h0, exp});
	endtask : rdChk
	task automatic runCase(input tcxu_case_s c, input int i);
		logic [63:0] va, pc;
		va = 64'h0000_00ab_cd45_6000 + 64'(i * 37);
		pc = 64'hffff_ffff_8000_1000 + 64'(i * 16);
		wr(tcxu_pkg::IDX_STATUS, {31'h0, c.exception_level_bit});
		pipe.issue(c.kind, c.st, c.wd, c.bd, 1'h0, va, pc);
		#1 chk({63'h0, excTake}, 64'h1);
		chk(excVector, {32'hffff_ffff, 20'hbfc00, c.off});
		chk({icInvalidate, dcCorrect}, {c.kind == 3'h3, c.kind == 3'h4});
		if (c.kind == 3'h3)
			chk({icInvLine, icInvWay}, va[8:0]);
		if (c.kind[2])
			chk({dcFixLine, dcFixWay}, va[8:0]);
		rdChk(tcxu_pkg::IDX_CAUSE, {c.bd, 24'h0, c.code, 2'h0});
		rdChk(tcxu_pkg::IDX_RETPC_LO, pc[31:0] - {c.bd, 2'h0});
		rdChk(tcxu_pkg::IDX_STATUS, 32'h1);
		if (c.kind < 3'h3) begin
			rdChk(tcxu_pkg::IDX_BADVA_HI, va[63:32]);
			rdChk(tcxu_pkg::IDX_PTE_LO, {9'h0, va[31:13], 4'h0});
			rdChk(tcxu_pkg::IDX_WPTE_LO, {va[40:13], 4'h0});
			rdChk(tcxu_pkg::IDX_TAG_LO, {va[31:13], 5'h0, curAsid});
		end else begin
			rdChk(tcxu_pkg::IDX_CFLOG, {19'h0, c.kind == 3'h3, 2'h0,
				2'(c.kind - 3'h2), 6'h0, va[1:0]});
			rdChk(tcxu_pkg::IDX_CFADR_LO, c.kind[2] ? va[31:0] : pc[31:0]);
		end
	endtask : runCase
	task automatic give_verdict();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		{rst_n, regWr, regRd, regAddr, regWdata} = '0;
		clkEn = 1'h1;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
		rdChk(tcxu_pkg::IDX_STATUS, 32'h0);
		rdChk(tcxu_pkg::IDX_BASE, 32'hbfc0_0000);
		wr(tcxu_pkg::IDX_CAUSE, 32'hffff_ffff);
		rdChk(tcxu_pkg::IDX_CAUSE, 32'h0);
		wr(6'h3f, 32'hffff_ffff);
		rdChk(6'h3f, 32'h0);
		for (int i = 0; i < 9; i++)
			runCase(CASES[i], i);
		pipe.issue(3'h0, 1'h0, 1'h0, 1'h0, 1'h1, 64'h1000, 64'h2000);
		#1 chk({63'h0, excTake}, 64'h0);
		pipe.probe(1'h1, 6'h2a);
		rdChk(tcxu_pkg::IDX_INDEX, 32'h2a);
		pipe.probe(1'h0, 6'h15);
		rdChk(tcxu_pkg::IDX_INDEX, 32'h2a);
		// Slot steps once per enabled edge and holds while clkEn is low
		@(posedge clk_sys);
		regRd <= 1'h1;
		regAddr <= tcxu_pkg::IDX_SLOT;
		@(posedge clk_sys);
		regRd <= 1'h0;
		#1 slotSeen = regRdata;
		rdChk(tcxu_pkg::IDX_SLOT, {26'h0, slotSeen[5:0] - 6'h2});
		@(posedge clk_sys);
		clkEn <= 1'h0;
		pipe.issue(3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 64'h3000, 64'h4000);
		#1 chk({63'h0, excTake}, 64'h0);
		@(posedge clk_sys);
		clkEn <= 1'h1;
		rdChk(tcxu_pkg::IDX_SLOT, {26'h0, slotSeen[5:0] - 6'h5});
		// A cached base must still yield an uncached cache-error entry
		wr(tcxu_pkg::IDX_BASE, 32'h8123_4567);
		rdChk(tcxu_pkg::IDX_BASE, 32'h8123_4000);
		pipe.issue(3'h3, 1'h0, 1'h0, 1'h0, 1'h0, 64'h5000, 64'h6000);
		#1 chk(excVector, 64'hffff_ffff_a123_4100);
		pipe.issue(3'h1, 1'h0, 1'h0, 1'h0, 1'h0, 64'h7000, 64'h8000);
		#1 chk(excVector, 64'hffff_ffff_8123_4180);
		// Reset in mid-run restores the level bit and the base
		@(posedge clk_sys);
		rst_n <= 1'h0;
		@(posedge clk_sys);
		rst_n <= 1'h1;
		rdChk(tcxu_pkg::IDX_STATUS, 32'h0);
		rdChk(tcxu_pkg::IDX_BASE, 32'hbfc0_0000);
		give_verdict();
	end
	// A run needs well under 400 cycles; this limit only cuts a hang
	initial begin
		#20000;
		err_count++;
		give_verdict();
	end
endmodule : tb
